// file: tb/pscm_top_sva.sv
// Port checker of the power-saving clock manager
`timescale 1ns/100ps
module pscm_chk
	import pscm_pkg::*;
(
	input wire logic             i_clk,
	input wire logic             i_rst,
	input wire logic             i_wb_cyc,
	input wire logic             i_wb_stb,
	input wire logic             i_power_save_instruction_valid,
	input wire logic             i_power_save_instruction_mode,
	input wire logic             i_irq_enabled,
	input wire logic             i_wdt_timeout,
	input wire logic             o_wb_ack,
	input wire logic             o_periph_clk_en,
	input wire logic             o_instr_clk_en,
	input wire logic [PWM_N-1:0] o_pwm_clk_en,
	input wire logic [PWM_N-1:0] o_pwm_disable,
	input wire logic             o_osc_stop,
	input wire logic [SRC_W-1:0] o_sys_src,
	input wire logic             o_pll_en,
	input wire logic             o_clk_fail,
	input wire logic             o_cpu_halted
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	// ********
	// Assertions
	// ********
	chk_ack_answer : assert property (
		i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack missing");
	chk_ack_pulse : assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
	chk_enter_sleep : assert property (
		i_power_save_instruction_valid && !o_cpu_halted && i_power_save_instruction_mode == POWER_SAVE_INSTRUCTION_SLEEP |=> o_cpu_halted
		&& !o_periph_clk_en && !o_instr_clk_en && o_pwm_clk_en == 3'h0)
		else $error("sleep entry wrong");
	chk_enter_idle : assert property (
		i_power_save_instruction_valid && !o_cpu_halted && i_power_save_instruction_mode == POWER_SAVE_INSTRUCTION_IDLE |=> o_cpu_halted
		&& o_periph_clk_en && !o_instr_clk_en) else $error("idle entry wrong");
	chk_no_halt : assert property (
		!o_cpu_halted && !i_power_save_instruction_valid |=> !o_cpu_halted) else $error("halt unbidden");
	chk_wake_up : assert property (
		o_cpu_halted && (i_irq_enabled || i_wdt_timeout) |=> !o_cpu_halted)
		else $error("no wake");
	chk_stop_osc : assert property (
		o_osc_stop |-> !o_periph_clk_en && o_cpu_halted) else $error("stop while running");
	chk_pwm_gate : assert property (
		(o_pwm_clk_en & o_pwm_disable & $past(o_pwm_disable)) == 3'h0)
		else $error("disabled pwm clocked");
	chk_pll_use : assert property (
		o_pll_en == ((o_sys_src == 3'h1 || o_sys_src == 3'h3) && !o_osc_stop))
		else $error("pll enable wrong");
	chk_fail_safe : assert property (
		$rose(o_clk_fail) |-> o_sys_src == SRC_SAFE) else $error("no fallback");

	cover property (i_power_save_instruction_valid && !o_cpu_halted);
	cover property ($rose(o_clk_fail));
	cover property ($changed(o_sys_src));
endmodule

// file: tb/pscm_top_tb.sv
// Self-checking bench of the power-saving clock manager
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
	$display("unexpected %s: expected %0h seen %0h", n, e, g); end end
module pscm_top_tb;
	import pscm_pkg::*;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, pv = 1'b0, pm = 1'b0;
	logic        irq = 1'b0, wdt = 1'b0, lock = 1'b0;
	logic [7:0]  adr = 8'h00, beat = 8'h00, alive = 8'hFF;
	logic [31:0] dat = 32'h0, rdat, r;
	logic [3:0]  sel = 4'h0, s;
	logic [15:0] d;
	logic [2:0]  pwe, pwd, src, p, t;
	logic        ack, pce, ice, ostop, pll, cfail, halt;
	int          fails = 0, n_tests = 0, tmo = 0, k, v;
	integer      c, cp;

	pscm_top #(.NS(NSRC), .FAIL_CYC(16)) dut_u (
		.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_dat(dat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_power_save_instruction_valid(pv), .i_power_save_instruction_mode(pm), .i_irq_enabled(irq), .i_wdt_timeout(wdt),
		.i_cfg_lock(lock), .i_osc_beat(beat), .o_periph_clk_en(pce), .o_instr_clk_en(ice),
		.o_pwm_clk_en(pwe), .o_pwm_disable(pwd), .o_osc_stop(ostop), .o_sys_src(src),
		.o_pll_en(pll), .o_clk_fail(cfail), .o_cpu_halted(halt));

	always #10 i_clk = ~i_clk;
	// Sources flagged alive keep their heartbeat toggling
	always @(posedge i_clk) beat <= beat ^ alive;
	always @(posedge i_clk)
	begin
		tmo <= tmo + 1;
		if (tmo == 20000)
		begin
			fails++;
			give_verdict();
		end
	end

	// ********
	// Tasks
	// ********
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] x,
		input logic [3:0] m);
		@(posedge i_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {16'h0000, x};
		sel <= m;
		do @(posedge i_clk); while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic psv(input logic m);
		@(posedge i_clk);
		pv <= 1'b1;
		pm <= m;
		@(posedge i_clk);
		pv <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic wake(input logic w);
		@(posedge i_clk);
		irq <= !w;
		wdt <= w;
		@(posedge i_clk);
		irq <= 1'b0;
		wdt <= 1'b0;
		@(posedge i_clk);
	endtask

	function automatic logic [31:0] pmd_exp(input logic [2:0] q);
		return {21'h0, q, 8'h00};
	endfunction

	// ********
	// Sequence
	// ********
	initial
	begin
		v = $urandom(32'h795D);
		tick(3);
		i_rst <= 1'b0;
		wb(1'b1, 8'h10, 16'hFFFF, 4'hF);
		for (k = 0; k < 5; k++)
		begin
			wb(1'b0, 8'(4 * k), 16'h0, 4'hF);
			`CHK("reset value", 32'h0, r)
		end
		p = 3'h0;
		repeat (8)
		begin
			d = 16'($urandom);
			s = 4'($urandom);
			wb(1'b1, ADDR_PERIPHERAL_DISABLE_CTRL_6, d, s);
			if (s[1])
				p = d[10:8];
			wb(1'b0, ADDR_PERIPHERAL_DISABLE_CTRL_6, 16'h0, 4'hF);
			`CHK("peripheral_disable_ctrl_6", pmd_exp(p), r)
			`CHK("pwm disable", p, pwd)
			`CHK("pwm clock", ~p, pwe)
		end
		wb(1'b1, ADDR_PERIPHERAL_DISABLE_CTRL_6, 16'h0, 4'h2);
		psv(POWER_SAVE_INSTRUCTION_SLEEP);
		`CHK("halted", 1'b1, halt)
		`CHK("periph sleep", 1'b0, pce)
		`CHK("cpu sleep", 1'b0, ice)
		`CHK("pwm sleep", 3'h0, pwe)
		tick(5);
		`CHK("osc stop", 1'b1, ostop)
		wake(1'b0);
		`CHK("woken", 1'b0, halt)
		`CHK("periph run", 1'b1, pce)
		wb(1'b0, ADDR_STATUS, 16'h0, 4'hF);
		`CHK("status irq", 32'h10, r)
		psv(POWER_SAVE_INSTRUCTION_IDLE);
		`CHK("periph idle", 1'b1, pce)
		`CHK("cpu idle", 1'b0, ice)
		`CHK("pwm idle", 3'h7, pwe)
		psv(POWER_SAVE_INSTRUCTION_SLEEP);
		`CHK("no sleep in idle", 1'b1, pce)
		wb(1'b0, ADDR_STATUS, 16'h0, 4'hF);
		`CHK("status idle", 2'b01, r[1:0])
		wake(1'b1);
		`CHK("woken wdt", 1'b0, halt)
		wb(1'b0, ADDR_STATUS, 16'h0, 4'hF);
		`CHK("status wdt", 3'b100, {r[5], r[1:0]})
		for (k = 0; k < 4; k++)
		begin
			wb(1'b1, ADDR_PWR_CTRL, 16'h8000 | 16'(k << 12), 4'h3);
			tick(4);
			c = 0;
			cp = 0;
			repeat (32)
			begin
				@(posedge i_clk);
				c += ice;
				cp += pce;
			end
			`CHK("doze cpu", 32 >> k, c)
			`CHK("doze periph", 32, cp)
		end
		wb(1'b1, ADDR_PWR_CTRL, 16'h0001, 4'h3);
		tick(2);
		`CHK("cpu off", 1'b0, ice)
		`CHK("periph on", 1'b1, pce)
		wb(1'b1, ADDR_PWR_CTRL, 16'h0, 4'h3);
		repeat (3)
		begin
			t = 3'($urandom_range(7, 1));
			wb(1'b1, ADDR_OSC_CTRL, {5'h00, t, 8'h00}, 4'h2);
			for (k = 0; k < 50 && src !== t; k++)
				tick(1);
			`CHK("switch", t, src)
			`CHK("pll", logic'(t == 3'h1 || t == 3'h3), pll)
			wb(1'b0, ADDR_OSC_CTRL, 16'h0, 4'hF);
			`CHK("current src", t, r[14:12])
		end
		lock <= 1'b1;
		tick(4);
		wb(1'b1, ADDR_OSC_CTRL, 16'h0, 4'h2);
		tick(40);
		`CHK("locked", t, src)
		lock <= 1'b0;
		alive <= 8'h01;
		for (k = 0; k < 200 && cfail !== 1'b1; k++)
			tick(1);
		`CHK("fail flag", 1'b1, cfail)
		`CHK("safe src", SRC_SAFE, src)
		// Switch towards a dead source: busy while waiting, then given up
		wb(1'b1, ADDR_OSC_CTRL, 16'h0200, 4'h2);
		wb(1'b0, ADDR_OSC_CTRL, 16'h0, 4'hF);
		`CHK("switch busy", 1'b1, r[0])
		tick(40);
		`CHK("dead source kept out", SRC_SAFE, src)
		wb(1'b0, ADDR_OSC_CTRL, 16'h0, 4'hF);
		`CHK("switch abort", 1'b0, r[0])
		alive <= 8'hFF;
		wb(1'b1, ADDR_OSC_CTRL, 16'h0008, 4'h1);
		tick(1);
		`CHK("fail clear", 1'b0, cfail)
		give_verdict();
	end
endmodule

bind pscm_top pscm_chk chk_u (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .i_power_save_instruction_valid(i_power_save_instruction_valid), .i_power_save_instruction_mode(i_power_save_instruction_mode),
	.i_irq_enabled(i_irq_enabled), .i_wdt_timeout(i_wdt_timeout), .o_wb_ack(o_wb_ack),
	.o_periph_clk_en(o_periph_clk_en), .o_instr_clk_en(o_instr_clk_en),
	.o_pwm_clk_en(o_pwm_clk_en), .o_pwm_disable(o_pwm_disable), .o_osc_stop(o_osc_stop),
	.o_sys_src(o_sys_src), .o_pll_en(o_pll_en), .o_clk_fail(o_clk_fail),
	.o_cpu_halted(o_cpu_halted));

// file: verilog/pscm_osc_if.sv
// Link between the power controller and the clock switch and fail monitor
`timescale 1ns/100ps
interface pscm_osc_if;
	import pscm_pkg::*;
	logic [SRC_W-1:0] req_src;
	logic             req;
	logic             stop;
	logic [SRC_W-1:0] cur_src;
	logic             busy;
	logic             fail;

	modport ctrl (output req_src, output req, output stop,
		input cur_src, input busy, input fail);
	modport mon (input req_src, input req, input stop,
		output cur_src, output busy, output fail);
endinterface

// file: verilog/pscm_osc_switch.sv
// Clock source switch and clock fail monitor
`timescale 1ns/100ps
module pscm_osc_switch
#(
	parameter int unsigned NS       = pscm_pkg::NSRC,
	parameter int unsigned FAIL_CYC = pscm_pkg::FAIL_CYCLES
)
(
	input  wire logic          i_clk,
	input  wire logic          i_rst,
	input  wire logic [NS-1:0] i_osc_beat,
	pscm_osc_if.mon            osc
);
	import pscm_pkg::*;

	localparam int unsigned CW = $clog2(FAIL_CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(FAIL_CYC - 1);

	logic [NS-1:0]    beat_s1;
	logic [NS-1:0]    beat_s2;
	logic [NS-1:0]    beat_s3;
	logic [NS-1:0]    beat_edge;
	logic [SRC_W-1:0] cur;
	logic [SRC_W-1:0] tgt;
	logic             busy;
	logic             fail;
	logic [CW-1:0]    beat_cnt;
	logic [CW-1:0]    wait_cnt;
	logic             lost;

	// ****************************************
	// Heartbeat synchronisers, one per source
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < NS; g++)
		begin : g_sync
			always_ff @(posedge i_clk or posedge i_rst)
			begin
				if (i_rst)
				begin
					beat_s1[g] <= 1'b0;
					beat_s2[g] <= 1'b0;
					beat_s3[g] <= 1'b0;
				end
				else
				begin
					beat_s1[g] <= i_osc_beat[g];
					beat_s2[g] <= beat_s1[g];
					beat_s3[g] <= beat_s2[g];
				end
			end
			assign beat_edge[g] = beat_s2[g] ^ beat_s3[g];
		end
	endgenerate

	// ****************************************
	// Fail monitor on the active source
	// ****************************************
	assign lost = !osc.stop && !beat_edge[cur] && (beat_cnt == LAST);

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			beat_cnt <= '0;
		else if (osc.stop || beat_edge[cur] || lost)
			beat_cnt <= '0;
		else
			beat_cnt <= beat_cnt + CW'(1);
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			fail <= 1'b0;
		else
			fail <= lost;
	end

	// ****************************************
	// Switch: wait for the new source to run, then change over
	// ****************************************
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			cur      <= SRC_RST;
			tgt      <= SRC_RST;
			busy     <= 1'b0;
			wait_cnt <= '0;
		end
		else if (lost)
		begin
			cur  <= SRC_SAFE;
			busy <= 1'b0;
		end
		else if (!busy)
		begin
			if (osc.req && osc.req_src != cur)
			begin
				tgt      <= osc.req_src;
				busy     <= 1'b1;
				wait_cnt <= '0;
			end
		end
		else if (beat_edge[tgt])
		begin
			cur  <= tgt;
			busy <= 1'b0;
		end
		else if (wait_cnt == LAST)
			busy <= 1'b0;
		else if (!osc.stop)
			wait_cnt <= wait_cnt + CW'(1);
	end

	assign osc.cur_src = cur;
	assign osc.busy    = busy;
	assign osc.fail    = fail;
endmodule

// file: verilog/pscm_pkg.sv
// Constants and types of the power-saving clock manager
package pscm_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned FAIL_TIME_NS  = 10000;
	localparam int unsigned FAIL_CYCLES   = (FAIL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int unsigned SRC_W   = 3;
	localparam int unsigned NSRC    = 8;
	localparam int unsigned PWM_N   = 3;
	localparam int unsigned ADR_W   = 8;
	localparam int unsigned DOZE_W  = 3;
	localparam int unsigned DOZE_CW = 7;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] ADDR_OSC_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PERIPHERAL_DISABLE_CTRL_6     = 8'h04;
	localparam logic [7:0] ADDR_PWR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_STATUS   = 8'h0C;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int unsigned OSC_BUSY_BIT    = 0;
	localparam int unsigned OSC_FAIL_BIT    = 3;
	localparam int unsigned OSC_LOCK_BIT    = 7;
	localparam int unsigned OSC_NEW_LSB     = 8;
	localparam int unsigned OSC_CUR_LSB     = 12;
	localparam int unsigned PERIPHERAL_DISABLE_CTRL_6_PWM_LSB    = 8;
	localparam int unsigned PWR_CPU_OFF_BIT = 0;
	localparam int unsigned PWR_DOZE_LSB    = 12;
	localparam int unsigned PWR_DOZE_EN_BIT = 15;
	localparam int unsigned ST_STATE_LSB    = 0;
	localparam int unsigned ST_WAKE_IRQ_BIT = 4;
	localparam int unsigned ST_WAKE_WDT_BIT = 5;

	// ****************************************
	// Reset values and encodings
	// ****************************************
	localparam logic [SRC_W-1:0]  SRC_RST      = 3'h0;
	localparam logic [SRC_W-1:0]  SRC_SAFE     = 3'h0;
	localparam logic [PWM_N-1:0]  PERIPHERAL_DISABLE_CTRL_6_RST     = 3'h0;
	localparam logic [DOZE_W-1:0] DOZE_RST     = 3'h0;
	localparam logic [NSRC-1:0]   PLL_SRC_MASK = 8'h0A;
	localparam logic              POWER_SAVE_INSTRUCTION_SLEEP = 1'b0;
	localparam logic              POWER_SAVE_INSTRUCTION_IDLE  = 1'b1;

	typedef enum logic [1:0]
	{
		PSCM_RUN   = 2'b00,
		PSCM_IDLE  = 2'b01,
		PSCM_SLEEP = 2'b10
	} pscm_pwr_e;

endpackage

// file: verilog/pscm_top.sv
// Power-saving clock manager: power modes, doze, clock gating, Wishbone registers
// Functional notes
// - Sleep or Idle is entered only by the power-save instruction, operand picks mode.
// - Sleep stops all clocks and execution until a wake event.
// - Idle halts the CPU; peripherals keep their clock and run.
// - Enabled interrupt, watchdog time-out or reset wakes from Sleep or Idle.
// - When unlocked, writing new oscillator select bits 10:8 requests a new source.
// - System clock source can be switched during operation without reset.
// - Separate peripheral and instruction clocks, normally equal in rate.
// - Doze with ratio 1:2 or lower runs CPU clock slower than peripherals.
// - Clock fail monitor detects a dead source and falls back safely.
// - Software gates CPU and individual peripheral clocks independently.
// - PLL multiplies selected sources to raise the operating clock.
`timescale 1ns/100ps
module pscm_top
#(
	parameter int unsigned NS       = pscm_pkg::NSRC,
	parameter int unsigned FAIL_CYC = pscm_pkg::FAIL_CYCLES
)
(
	input  wire logic                          i_clk,
	input  wire logic                          i_rst,
	input  wire logic                          i_wb_cyc,
	input  wire logic                          i_wb_stb,
	input  wire logic                          i_wb_we,
	input  wire logic [pscm_pkg::ADR_W-1:0]    i_wb_adr,
	input  wire logic [31:0]                   i_wb_dat,
	input  wire logic [3:0]                    i_wb_sel,
	output logic      [31:0]                   o_wb_dat,
	output logic                               o_wb_ack,
	input  wire logic                          i_power_save_instruction_valid,
	input  wire logic                          i_power_save_instruction_mode,
	input  wire logic                          i_irq_enabled,
	input  wire logic                          i_wdt_timeout,
	input  wire logic                          i_cfg_lock,
	input  wire logic [NS-1:0]                 i_osc_beat,
	output logic                               o_periph_clk_en,
	output logic                               o_instr_clk_en,
	output logic [pscm_pkg::PWM_N-1:0]         o_pwm_clk_en,
	output logic [pscm_pkg::PWM_N-1:0]         o_pwm_disable,
	output logic                               o_osc_stop,
	output logic [pscm_pkg::SRC_W-1:0]         o_sys_src,
	output logic                               o_pll_en,
	output logic                               o_clk_fail,
	output logic                               o_cpu_halted
);
	import pscm_pkg::*;

	pscm_osc_if osc ();

	pscm_pwr_e           state;
	pscm_pwr_e           next_state;
	logic                lock_s1;
	logic                lock_s2;
	logic                wb_req;
	logic                wr;
	logic [SRC_W-1:0]    new_osc_select;
	logic                sw_req;
	logic                fail_flag;
	logic [PWM_N-1:0]    pwm_dis;
	logic                doze_en;
	logic [DOZE_W-1:0]   doze_ratio;
	logic                cpu_off;
	logic                wake_irq;
	logic                wake_wdt;
	logic                wake;
	logic [DOZE_CW-1:0]  doze_cnt;
	logic [DOZE_CW-1:0]  doze_mask;
	logic                doze_tick;
	logic [15:0]         rd_val;

	// ****************************************
	// Lock strap synchroniser
	// ****************************************
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			lock_s1 <= 1'b0;
			lock_s2 <= 1'b0;
		end
		else
		begin
			lock_s1 <= i_cfg_lock;
			lock_s2 <= lock_s1;
		end
	end

	// ****************************************
	// Wishbone slave: one wait state, ack for one cycle
	// ****************************************
	assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign wr     = wb_req && i_wb_we;

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			o_wb_ack <= 1'b0;
		else
			o_wb_ack <= wb_req;
	end

	always_comb
	begin
		rd_val = 16'h0000;
		if (i_wb_adr == ADDR_OSC_CTRL)
		begin
			rd_val[OSC_BUSY_BIT]                 = osc.busy;
			rd_val[OSC_FAIL_BIT]                 = fail_flag;
			rd_val[OSC_LOCK_BIT]                 = lock_s2;
			rd_val[OSC_NEW_LSB +: SRC_W]         = new_osc_select;
			rd_val[OSC_CUR_LSB +: SRC_W]         = osc.cur_src;
		end
		else if (i_wb_adr == ADDR_PERIPHERAL_DISABLE_CTRL_6)
			rd_val[PERIPHERAL_DISABLE_CTRL_6_PWM_LSB +: PWM_N]        = pwm_dis;
		else if (i_wb_adr == ADDR_PWR_CTRL)
		begin
			rd_val[PWR_CPU_OFF_BIT]              = cpu_off;
			rd_val[PWR_DOZE_LSB +: DOZE_W]       = doze_ratio;
			rd_val[PWR_DOZE_EN_BIT]              = doze_en;
		end
		else if (i_wb_adr == ADDR_STATUS)
		begin
			rd_val[ST_STATE_LSB +: 2]            = state;
			rd_val[ST_WAKE_IRQ_BIT]              = wake_irq;
			rd_val[ST_WAKE_WDT_BIT]              = wake_wdt;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			o_wb_dat <= 32'h00000000;
		else if (wb_req && !i_wb_we)
			o_wb_dat <= {16'h0000, rd_val};
	end

	// ****************************************
	// Oscillator control register
	// ****************************************
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			new_osc_select <= SRC_RST;
			sw_req         <= 1'b0;
		end
		else if (wr && i_wb_adr == ADDR_OSC_CTRL && i_wb_sel[1] && !lock_s2)
		begin
			new_osc_select <= i_wb_dat[OSC_NEW_LSB +: SRC_W];
			sw_req         <= 1'b1;
		end
		else
			sw_req <= 1'b0;
	end

	// Fail flag is sticky; a new failure wins over a software clear
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			fail_flag <= 1'b0;
		else if (osc.fail)
			fail_flag <= 1'b1;
		else if (wr && i_wb_adr == ADDR_OSC_CTRL && i_wb_sel[0] && i_wb_dat[OSC_FAIL_BIT])
			fail_flag <= 1'b0;
	end

	assign osc.req_src = new_osc_select;
	assign osc.req     = sw_req;
	assign osc.stop    = (state == PSCM_SLEEP);

	pscm_osc_switch #(.NS(NS), .FAIL_CYC(FAIL_CYC)) u_switch
	(
		.i_clk      (i_clk),
		.i_rst      (i_rst),
		.i_osc_beat (i_osc_beat),
		.osc        (osc)
	);

	// ****************************************
	// Peripheral disable register
	// ****************************************
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			pwm_dis <= PERIPHERAL_DISABLE_CTRL_6_RST;
		else if (wr && i_wb_adr == ADDR_PERIPHERAL_DISABLE_CTRL_6 && i_wb_sel[1])
			pwm_dis <= i_wb_dat[PERIPHERAL_DISABLE_CTRL_6_PWM_LSB +: PWM_N];
	end

	// ****************************************
	// Power control register
	// ****************************************
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			doze_en    <= 1'b0;
			doze_ratio <= DOZE_RST;
			cpu_off    <= 1'b0;
		end
		else if (wr && i_wb_adr == ADDR_PWR_CTRL)
		begin
			if (i_wb_sel[1])
			begin
				doze_en    <= i_wb_dat[PWR_DOZE_EN_BIT];
				doze_ratio <= i_wb_dat[PWR_DOZE_LSB +: DOZE_W];
			end
			if (i_wb_sel[0])
				cpu_off <= i_wb_dat[PWR_CPU_OFF_BIT];
		end
	end

	// ****************************************
	// Power mode state machine
	// ****************************************
	assign wake = i_irq_enabled || i_wdt_timeout;

	always_comb
	begin
		next_state = state;
		case (state)
			PSCM_RUN:
			begin
				if (i_power_save_instruction_valid && i_power_save_instruction_mode == POWER_SAVE_INSTRUCTION_SLEEP)
					next_state = PSCM_SLEEP;
				else if (i_power_save_instruction_valid && i_power_save_instruction_mode == POWER_SAVE_INSTRUCTION_IDLE)
					next_state = PSCM_IDLE;
			end
			PSCM_IDLE, PSCM_SLEEP:
			begin
				if (wake)
					next_state = PSCM_RUN;
			end
			default:
				next_state = PSCM_RUN;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			state <= PSCM_RUN;
		else
			state <= next_state;
	end

	// Cause of the last wake-up, kept until the next one
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			wake_irq <= 1'b0;
			wake_wdt <= 1'b0;
		end
		else if (state != PSCM_RUN && wake)
		begin
			wake_irq <= i_irq_enabled;
			wake_wdt <= i_wdt_timeout;
		end
	end

	// ****************************************
	// Doze divider for the instruction clock
	// ****************************************
	assign doze_mask = DOZE_CW'((8'h01 << doze_ratio) - 8'h01);
	assign doze_tick = !doze_en || ((doze_cnt & doze_mask) == '0);

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			doze_cnt <= '0;
		else if (state != PSCM_RUN || !doze_en)
			doze_cnt <= '0;
		else
			doze_cnt <= doze_cnt + DOZE_CW'(1);
	end

	// ****************************************
	// Clock enables and status outputs
	// ****************************************
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_periph_clk_en <= 1'b0;
			o_instr_clk_en  <= 1'b0;
			o_pwm_clk_en    <= '0;
			o_cpu_halted    <= 1'b0;
		end
		else
		begin
			o_periph_clk_en <= (next_state != PSCM_SLEEP);
			o_instr_clk_en  <= (next_state == PSCM_RUN) && !cpu_off && doze_tick;
			o_pwm_clk_en    <= {PWM_N{next_state != PSCM_SLEEP}} & ~pwm_dis;
			o_cpu_halted    <= (next_state != PSCM_RUN);
		end
	end

	assign o_pwm_disable = pwm_dis;
	assign o_osc_stop    = (state == PSCM_SLEEP);
	assign o_sys_src     = osc.cur_src;
	assign o_pll_en      = PLL_SRC_MASK[osc.cur_src] && !o_osc_stop;
	assign o_clk_fail    = fail_flag;
endmodule
